// file: verilog/baud_regs.vh
// Register offsets, field positions, reset values and divider constants
// Included by the baud generator design file and its bench files; definitions only
`ifndef BAUD_REGS_VH
`define BAUD_REGS_VH

`define OFS_BAUD_CONTROL 8'h00
`define OFS_RX_STATUS_CONTROL 8'h04
`define OFS_DIVISOR_LOW 8'h08
`define OFS_DIVISOR_HIGH 8'h0C
`define OFS_TX_STATUS_CONTROL 8'h10
`define OFS_RX_DATA 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1C

`define BC_OVF 7
`define BC_IDLE 6
`define BC_POL 4
`define BC_WIDE 3
`define BC_WAKE 1
`define BC_CAL_EN 0

`define TX_SYNC 4
`define TX_HIGH 2
`define TX_EMPTY 1

`define IRQ_DONE 0
`define IRQ_OVF 1

`define RST_BYTE 8'h00
`define RST_TX_STATUS 8'h02
`define RST_DIVISOR 8'h00
`define RST_IRQ 2'h0

`define DIV_SLOW 9'h03F
`define DIV_MID 9'h00F
`define DIV_FAST 9'h003
`define CAL_DIV_SLOW 9'h1FF
`define CAL_DIV_MID 9'h07F
`define CAL_DIV_FAST 9'h01F

`define CAL_EDGE_COUNT 3'h5
`define CAL_COUNT_START 16'h0001
`define CAL_COUNT_MAX 16'hFFFF

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: verilog/rate_prescaler.v
// Programmable prescaler giving one tick every (period_m1 + 1) clocks
// Assumes period_m1 is stable between restarts
`timescale 1ns/1ps
`default_nettype none
module rate_prescaler (
    input wire sys_clk,
    input wire srst,
    input wire restart,
    input wire [8:0] period_m1,
    output reg tick
);
    reg [8:0] cnt_reg;
    reg [8:0] cnt_next;
    reg tick_next;

    always @* begin
        cnt_next = cnt_reg + 9'h001;
        tick_next = 1'b0;
        if (restart) begin
            cnt_next = 9'h000;
        end else if (cnt_reg >= period_m1) begin
            // Compare by >= so a shrinking period never runs past its end
            cnt_next = 9'h000;
            tick_next = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            cnt_reg <= 9'h000;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule
`default_nettype wire

// file: verilog/baud_generator_autobaud.v
// Baud rate generator with automatic baud detection, AXI4-Lite register slave
// Assumes rx_in is already synchronous to sys_clk and idles high
//
// Behaviour
// - Baud is clock over 64, 16 or 4 times divisor plus one by mode bits.
// - Setting auto-baud enable starts calibration; receiver held idle meanwhile.
// - During detection the receive line times the counter over a 0x55 byte.
// - Divisor pair starts counting at first rising edge after start bit.
// - Fifth rising edge: keep count, clear enable, set receive interrupt flag.
// - Reading receive data clears the receive flag; software discards the value.
// - Detection clock is clock over 512, 128, 128 or 32 by divider bits.
// - Both divisor bytes form one 16-bit counter during detection, always.
// - Eight bit times at one eighth rate yield the average bit time.
// - Detection counter starts at one; software subtracts one afterwards.
// - With wake-on-break set, detection runs on the character after the break.
// - Any divisor byte write restarts the generator timer at once.
// - Counter overflow before fifth edge sets overflow flag; counting continues.
// - Overflow flag clears only once auto-baud enable is already clear.
`timescale 1ns/1ps
`default_nettype none
`include "baud_regs.vh"
module baud_generator_autobaud (
    input wire sys_clk,
    input wire srst,
    input wire rx_in,
    output reg baud_tick,
    output wire receiver_hold_idle,
    output wire receive_interrupt_flag,
    output wire irq,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    localparam ST_OFF = 3'd0;
    localparam ST_BREAK = 3'd1;
    localparam ST_BRKLOW = 3'd2;
    localparam ST_START = 3'd3;
    localparam ST_FIRST = 3'd4;
    localparam ST_COUNT = 3'd5;

    // Divider code: 0 slow, 1 mid, 2 fast
    function [1:0] div_code;
        input wide;
        input high;
        input sync;
        begin
            if (sync || (wide && high)) begin
                div_code = 2'd2;
            end else if (wide || high) begin
                div_code = 2'd1;
            end else begin
                div_code = 2'd0;
            end
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `OFS_BAUD_CONTROL) || (addr == `OFS_RX_STATUS_CONTROL) ||
                (addr == `OFS_DIVISOR_LOW) || (addr == `OFS_DIVISOR_HIGH) ||
                (addr == `OFS_TX_STATUS_CONTROL) || (addr == `OFS_RX_DATA) ||
                (addr == `OFS_IRQ_STATUS) || (addr == `OFS_IRQ_MASK);
        end
    endfunction

    reg aw_hold_reg;
    reg [7:0] aw_addr_reg;
    reg w_hold_reg;
    reg [7:0] w_data_reg;
    reg w_lane_reg;
    reg cal_en_reg;
    reg ovf_reg;
    reg wake_reg;
    reg wide_reg;
    reg pol_reg;
    reg [4:0] rx_ctrl_reg;
    reg [7:0] tx_ctrl_reg;
    reg [7:0] div_low_reg;
    reg [7:0] div_high_reg;
    reg rx_flag_reg;
    reg [1:0] irq_status_reg;
    reg [1:0] irq_mask_reg;
    reg [2:0] state_reg;
    reg [2:0] edge_cnt_reg;
    reg rx_prev_reg;
    reg [15:0] gen_cnt_reg;
    reg [7:0] read_value;
    reg [8:0] period_m1;

    wire wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    wire wr_en = wr_fire && w_lane_reg;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rx_rise = rx_in && !rx_prev_reg;
    wire rx_fall = !rx_in && rx_prev_reg;
    wire div_write = wr_en && ((aw_addr_reg == `OFS_DIVISOR_LOW) || (aw_addr_reg == `OFS_DIVISOR_HIGH));
    wire counting = (state_reg == ST_COUNT);
    wire cal_active = (state_reg != ST_OFF);
    wire start_count = (state_reg == ST_FIRST) && rx_rise;
    wire cal_done = counting && rx_rise && ((edge_cnt_reg + 3'h1) == `CAL_EDGE_COUNT);
    wire sw_cal_clear = wr_en && (aw_addr_reg == `OFS_BAUD_CONTROL) && !w_data_reg[`BC_CAL_EN];
    wire prescale_tick;
    wire [1:0] code = div_code(wide_reg, tx_ctrl_reg[`TX_HIGH], tx_ctrl_reg[`TX_SYNC]);
    wire [1:0] cal_code = div_code(wide_reg, tx_ctrl_reg[`TX_HIGH], 1'b0);
    wire [15:0] gen_limit = wide_reg ? {div_high_reg, div_low_reg} : {8'h00, div_low_reg};
    wire [15:0] pair = {div_high_reg, div_low_reg};
    wire [15:0] pair_inc = pair + 16'h0001;
    wire ovf_event = counting && prescale_tick && !cal_done && (pair == `CAL_COUNT_MAX);

    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign receiver_hold_idle = cal_active;
    assign receive_interrupt_flag = rx_flag_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);

    // Base clock in normal use; during detection eight times slower than the base without the sync bit
    always @* begin
        period_m1 = `DIV_SLOW;
        if (cal_active) begin
            case (cal_code)
                2'd0: period_m1 = `CAL_DIV_SLOW;
                2'd1: period_m1 = `CAL_DIV_MID;
                default: period_m1 = `CAL_DIV_FAST;
            endcase
        end else begin
            case (code)
                2'd0: period_m1 = `DIV_SLOW;
                2'd1: period_m1 = `DIV_MID;
                default: period_m1 = `DIV_FAST;
            endcase
        end
    end

    rate_prescaler prescaler (
        .sys_clk(sys_clk),
        .srst(srst),
        .restart(div_write || start_count),
        .period_m1(period_m1),
        .tick(prescale_tick)
    );

    // Write channel: address and data are taken in either order
    always @(posedge sys_clk) begin
        if (srst) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @* begin
        case (s_axi_araddr)
            `OFS_BAUD_CONTROL: read_value = {ovf_reg, !cal_active, 1'b0, pol_reg,
                wide_reg, 1'b0, wake_reg, cal_en_reg};
            `OFS_RX_STATUS_CONTROL: read_value = {rx_ctrl_reg, 3'h0};
            `OFS_DIVISOR_LOW: read_value = div_low_reg;
            `OFS_DIVISOR_HIGH: read_value = div_high_reg;
            `OFS_TX_STATUS_CONTROL: read_value = tx_ctrl_reg;
            `OFS_IRQ_STATUS: read_value = {6'h00, irq_status_reg};
            `OFS_IRQ_MASK: read_value = {6'h00, irq_mask_reg};
            default: read_value = 8'h00;
        endcase
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, read_value};
            s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Control registers
    always @(posedge sys_clk) begin
        if (srst) begin
            cal_en_reg <= 1'b0;
            wake_reg <= 1'b0;
            wide_reg <= 1'b0;
            pol_reg <= 1'b0;
            ovf_reg <= 1'b0;
            rx_ctrl_reg <= 5'h00;
            tx_ctrl_reg <= `RST_TX_STATUS;
            irq_mask_reg <= `RST_IRQ;
        end else begin
            if (wr_en && (aw_addr_reg == `OFS_BAUD_CONTROL)) begin
                cal_en_reg <= w_data_reg[`BC_CAL_EN];
                wake_reg <= w_data_reg[`BC_WAKE];
                wide_reg <= w_data_reg[`BC_WIDE];
                pol_reg <= w_data_reg[`BC_POL];
                // Clear lands only when enable was already low
                if (!w_data_reg[`BC_OVF] && !cal_en_reg) begin
                    ovf_reg <= 1'b0;
                end
            end
            if (wr_en && (aw_addr_reg == `OFS_RX_STATUS_CONTROL)) begin
                rx_ctrl_reg <= w_data_reg[7:3];
            end
            if (wr_en && (aw_addr_reg == `OFS_TX_STATUS_CONTROL)) begin
                // Empty flag stays set: no transmitter in this block
                tx_ctrl_reg <= {w_data_reg[7:2], 1'b1, w_data_reg[0]};
            end
            if (wr_en && (aw_addr_reg == `OFS_IRQ_MASK)) begin
                irq_mask_reg <= w_data_reg[1:0];
            end
            if (state_reg == ST_BRKLOW && rx_rise) begin
                wake_reg <= 1'b0;
            end
            if (cal_done) begin
                cal_en_reg <= 1'b0;
            end
            if (ovf_event) begin
                ovf_reg <= 1'b1;
            end
        end
    end

    // Detection sequencer
    always @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= ST_OFF;
            edge_cnt_reg <= 3'h0;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_prev_reg <= rx_in;
            if (!cal_en_reg || sw_cal_clear) begin
                state_reg <= ST_OFF;
            end else begin
                case (state_reg)
                    ST_OFF: state_reg <= wake_reg ? ST_BREAK : ST_START;
                    ST_BREAK: begin
                        if (rx_fall) begin
                            state_reg <= ST_BRKLOW;
                        end
                    end
                    ST_BRKLOW: begin
                        if (rx_rise) begin
                            state_reg <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (rx_fall) begin
                            state_reg <= ST_FIRST;
                        end
                    end
                    ST_FIRST: begin
                        if (rx_rise) begin
                            state_reg <= ST_COUNT;
                            edge_cnt_reg <= 3'h1;
                        end
                    end
                    ST_COUNT: begin
                        if (cal_done) begin
                            state_reg <= ST_OFF;
                        end else if (rx_rise) begin
                            edge_cnt_reg <= edge_cnt_reg + 3'h1;
                        end
                    end
                    default: state_reg <= ST_OFF;
                endcase
            end
        end
    end

    // Divisor pair: software value, or the detection counter
    always @(posedge sys_clk) begin
        if (srst) begin
            div_low_reg <= `RST_DIVISOR;
            div_high_reg <= `RST_DIVISOR;
        end else if (start_count) begin
            {div_high_reg, div_low_reg} <= `CAL_COUNT_START;
        end else if (counting) begin
            // Count at 1/8 rate for 8 bits so the result is one bit at base rate
            if (prescale_tick && !cal_done) begin
                {div_high_reg, div_low_reg} <= pair_inc;
            end
        end else if (wr_en) begin
            if (aw_addr_reg == `OFS_DIVISOR_LOW) begin
                div_low_reg <= w_data_reg;
            end
            if (aw_addr_reg == `OFS_DIVISOR_HIGH) begin
                div_high_reg <= w_data_reg;
            end
        end
    end

    // Baud timer
    always @(posedge sys_clk) begin
        if (srst) begin
            gen_cnt_reg <= 16'h0000;
            baud_tick <= 1'b0;
        end else begin
            baud_tick <= 1'b0;
            if (div_write || cal_active) begin
                gen_cnt_reg <= 16'h0000;
            end else if (prescale_tick) begin
                if (gen_cnt_reg >= gen_limit) begin
                    gen_cnt_reg <= 16'h0000;
                    baud_tick <= 1'b1;
                end else begin
                    gen_cnt_reg <= gen_cnt_reg + 16'h0001;
                end
            end
        end
    end

    // Flags: a set in the same cycle as a clear wins
    always @(posedge sys_clk) begin
        if (srst) begin
            rx_flag_reg <= 1'b0;
            irq_status_reg <= `RST_IRQ;
        end else begin
            if (cal_done) begin
                rx_flag_reg <= 1'b1;
            end else if (rd_fire && s_axi_araddr == `OFS_RX_DATA) begin
                rx_flag_reg <= 1'b0;
            end
            if (wr_en && (aw_addr_reg == `OFS_IRQ_STATUS)) begin
                irq_status_reg <= (irq_status_reg & ~w_data_reg[1:0]) | {ovf_event, cal_done};
            end else begin
                irq_status_reg <= irq_status_reg | {ovf_event, cal_done};
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/baud_monitor.sv
// Port checker for the baud generator with auto-baud detection
// Assumes it is bound to baud_generator_autobaud and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "baud_regs.vh"
module baud_monitor (
    input wire sys_clk,
    input wire srst,
    input wire baud_tick,
    input wire receiver_hold_idle,
    input wire receive_interrupt_flag,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while response pending");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    // Shortest legal period is one fast base tick of four clocks
    tick_pulse_a: assert property (baud_tick |=> !baud_tick [*3])
        else $error("baud ticks closer than four clocks");
    tick_quiet_a: assert property (receiver_hold_idle && $past(receiver_hold_idle) |-> !baud_tick)
        else $error("baud tick during detection");
    done_flag_a: assert property ($rose(receive_interrupt_flag) |->
        $past(receiver_hold_idle) || $past(receiver_hold_idle, 2))
        else $error("receive flag set outside detection");
    flag_clear_a: assert property ($fell(receive_interrupt_flag) |->
        $past(s_axi_arvalid && s_axi_araddr == `OFS_RX_DATA))
        else $error("receive flag cleared without data read");
endmodule
bind baud_generator_autobaud baud_monitor u_baud_monitor (
    .sys_clk(sys_clk),
    .srst(srst),
    .baud_tick(baud_tick),
    .receiver_hold_idle(receiver_hold_idle),
    .receive_interrupt_flag(receive_interrupt_flag),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// file: bench/sync_char_source.sv
// Remote transmitter model sending one sync character, optionally after a break
// Assumes send is a one-cycle request given while busy is low
`timescale 1ns/1ps
`default_nettype none
module sync_char_source (
    input wire sys_clk,
    input wire send,
    input wire with_break,
    input wire [15:0] bit_cycles,
    output logic rx_in,
    output logic busy
);
    localparam logic [7:0] SYNC_CHAR = 8'h55;
    integer i;
    initial begin
        rx_in = 1'b1;
        busy = 1'b0;
    end
    task automatic hold_level(input logic v, input integer bits);
        rx_in <= v;
        repeat (bits * bit_cycles) @(posedge sys_clk);
    endtask
    // Line idles high between characters, as a real transmitter leaves it
    always begin
        @(posedge sys_clk);
        if (send) begin
            busy <= 1'b1;
            if (with_break) begin
                hold_level(1'b0, 12);
                hold_level(1'b1, 2);
            end
            hold_level(1'b0, 1);
            for (i = 0; i < 8; i = i + 1) begin
                hold_level(SYNC_CHAR[i], 1);
            end
            hold_level(1'b1, 1);
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: bench/tb_baud_generator_autobaud.sv
// Self-checking bench for the baud generator with auto-baud detection
// Assumes the sync character source drives rx_in and the bench is bus master
`timescale 1ns/1ps
`default_nettype none
`include "baud_regs.vh"
module tb_baud_generator_autobaud;
    logic sys_clk, srst, rx_in, baud_tick, receiver_hold_idle, receive_interrupt_flag, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic send, with_break, src_busy;
    logic [15:0] bit_cycles;
    integer mismatches, samples_checked;
    baud_generator_autobaud u_baud_generator_autobaud (.sys_clk(sys_clk), .srst(srst), .rx_in(rx_in),
        .baud_tick(baud_tick), .receiver_hold_idle(receiver_hold_idle),
        .receive_interrupt_flag(receive_interrupt_flag), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    sync_char_source u_sync_char_source (.sys_clk(sys_clk), .send(send), .with_break(with_break),
        .bit_cycles(bit_cycles), .rx_in(rx_in), .busy(src_busy));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task stop_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task check(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task timed_out;
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h expected %h", $time, 1'b0, 1'b1);
        stop_test;
    endtask
    // Ready is sampled mid-cycle so the release lands just after the taking edge
    task axi_write(input [7:0] addr, input [31:0] data);
        integer n;
        logic a_t, w_t;
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        a_t = 1'b0;
        w_t = 1'b0;
        for (n = 0; n < 50 && !(a_t && w_t); n = n + 1) begin
            @(negedge sys_clk);
            a_t = a_t || s_axi_awready;
            w_t = w_t || s_axi_wready;
            @(posedge sys_clk);
            if (a_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
        if (!(a_t && w_t)) timed_out;
        a_t = 1'b0;
        for (n = 0; n < 50 && !a_t; n = n + 1) begin
            @(negedge sys_clk);
            a_t = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge sys_clk);
        end
        s_axi_bready <= 1'b0;
        // One idle edge so a following call never re-raises bready in the same step
        @(posedge sys_clk);
        if (!a_t) timed_out;
    endtask
    task axi_read(input [7:0] addr, output [31:0] data);
        integer n;
        logic done;
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 50 && !done; n = n + 1) begin
            @(negedge sys_clk);
            done = s_axi_arready;
            @(posedge sys_clk);
        end
        s_axi_arvalid <= 1'b0;
        if (!done) timed_out;
        done = 1'b0;
        for (n = 0; n < 50 && !done; n = n + 1) begin
            @(negedge sys_clk);
            done = s_axi_rvalid;
            data = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge sys_clk);
        end
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
        if (!done) timed_out;
    endtask
    task send_char(input [15:0] cycles, input logic brk);
        integer n;
        // The source misses a request while its stop bit still runs
        for (n = 0; n < 5000 && src_busy; n = n + 1) @(posedge sys_clk);
        if (src_busy) timed_out;
        bit_cycles <= cycles;
        with_break <= brk;
        send <= 1'b1;
        @(posedge sys_clk);
        send <= 1'b0;
        for (n = 0; n < 5000 && receive_interrupt_flag !== 1'b1; n = n + 1) @(posedge sys_clk);
        if (n == 5000) timed_out;
        @(posedge sys_clk);
    endtask
    task count_ticks(output integer n);
        logic seen;
        seen = 1'b0;
        for (n = 0; n < 1000 && !seen; n = n + 1) begin
            @(negedge sys_clk);
            seen = baud_tick;
        end
        @(posedge sys_clk);
        if (!seen) timed_out;
    endtask
    task check_reset_values;
        logic [31:0] d;
        axi_read(`OFS_BAUD_CONTROL, d);
        check(d, 32'h00000040);
        axi_read(`OFS_TX_STATUS_CONTROL, d);
        check(d, 32'h00000002);
        axi_read(`OFS_DIVISOR_LOW, d);
        check(d, 32'h00000000);
        axi_write(`OFS_RX_STATUS_CONTROL, 32'hFFFFFFFF);
        axi_read(`OFS_RX_STATUS_CONTROL, d);
        check(d, 32'h000000F8);
        axi_write(8'h20, 32'h000000FF);
        check({30'h0, resp}, {30'h0, `RESP_SLVERR});
        axi_read(8'h20, d);
        check(d, 32'h00000000);
        check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    endtask
    // Bit time of 7/16 of the detection divisor gives three and a half ticks over the eight timed bits
    task detect_in_each_mode;
        integer m, dv;
        logic [31:0] d;
        for (m = 0; m < 4; m = m + 1) begin
            dv = (m == 0) ? 512 : (m == 3) ? 32 : 128;
            axi_write(`OFS_TX_STATUS_CONTROL, {29'h0, m[0], 2'h0});
            axi_write(`OFS_IRQ_MASK, {31'h0, m[0]});
            axi_write(`OFS_BAUD_CONTROL, {28'h0, m[1], 3'h1});
            @(negedge sys_clk);
            check({31'h0, receiver_hold_idle}, 32'h1);
            @(posedge sys_clk);
            send_char(16'(7 * dv / 16), 1'b0);
            axi_read(`OFS_DIVISOR_LOW, d);
            check(d, 32'h00000004);
            axi_read(`OFS_DIVISOR_HIGH, d);
            check(d, 32'h00000000);
            axi_read(`OFS_BAUD_CONTROL, d);
            check({31'h0, d[0]}, 32'h0);
            axi_read(`OFS_IRQ_STATUS, d);
            check(d, 32'h00000001);
            check({31'h0, irq}, {31'h0, m[0]});
            axi_read(`OFS_RX_DATA, d);
            @(negedge sys_clk);
            check({31'h0, receive_interrupt_flag}, 32'h0);
            @(posedge sys_clk);
            axi_write(`OFS_IRQ_STATUS, 32'h00000001);
            check({31'h0, irq}, 32'h0);
        end
    endtask
    task detect_after_break;
        logic [31:0] d;
        axi_write(`OFS_BAUD_CONTROL, 32'h00000001);
        axi_write(`OFS_BAUD_CONTROL, 32'h00000000);
        check({31'h0, receiver_hold_idle}, 32'h0);
        axi_write(`OFS_TX_STATUS_CONTROL, 32'h00000004);
        axi_write(`OFS_BAUD_CONTROL, 32'h0000000B);
        send_char(16'd14, 1'b1);
        axi_read(`OFS_DIVISOR_LOW, d);
        check(d, 32'h00000004);
        axi_read(`OFS_BAUD_CONTROL, d);
        check({30'h0, d[1:0]}, 32'h0);
        axi_read(`OFS_RX_DATA, d);
        axi_write(`OFS_IRQ_STATUS, 32'h00000001);
    endtask
    task rate_in_each_mode;
        integer m, n, period;
        for (m = 0; m < 5; m = m + 1) begin
            period = 3 * ((m == 0) ? 64 : (m < 3) ? 16 : 4);
            axi_write(`OFS_TX_STATUS_CONTROL, {27'h0, m == 4, 1'b0, m == 1 || m == 3, 2'h0});
            axi_write(`OFS_BAUD_CONTROL, {28'h0, m == 2 || m == 3, 3'h0});
            axi_write(`OFS_DIVISOR_HIGH, 32'h00000000);
            axi_write(`OFS_DIVISOR_LOW, 32'h00000002);
            count_ticks(n);
            check({31'h0, n >= period - 4 && n <= period}, 32'h1);
            count_ticks(n);
            check(n, period);
        end
    endtask
    initial begin
        mismatches = 0;
        samples_checked = 0;
        srst = 1'b1;
        send = 1'b0;
        with_break = 1'b0;
        bit_cycles = 16'd14;
        resp = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        check_reset_values;
        detect_in_each_mode;
        detect_after_break;
        rate_in_each_mode;
        stop_test;
    end
endmodule
`default_nettype wire
